// [pkg/scd_pkg.sv]
package scd_pkg;

   // Effective system divisor code, divide ratio is code plus one
   typedef logic [5:0] scd_div_t;

   // PWM predivide code
   typedef logic [2:0] scd_pwm_code_t;

   // Register bus address
   typedef logic [7:0] scd_addr_t;

endpackage : scd_pkg

// [pkg/scd_regs.svh]
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

// Register offsets (byte addresses)
`define SCD_RUN_CFG_OFS 8'h60
`define SCD_SECOND_CFG_OFS 8'h70

// Run-mode configuration field positions
`define SCD_SYS_DIV_HI 26
`define SCD_SYS_DIV_LO 23
`define SCD_SYS_DIV_EN_BIT 22
`define SCD_PWM_DIV_EN_BIT 20
`define SCD_PWM_PRE_HI 19
`define SCD_PWM_PRE_LO 17
`define SCD_POWER_DOWN_BIT 13
`define SCD_FIXED_ONE_BIT 12
`define SCD_BYPASS_BIT 11

// Second configuration field positions
`define SCD_ALT_SEL_BIT 31
`define SCD_ALT_DIV_HI 28
`define SCD_ALT_DIV_LO 23

// Reset values
`define SCD_SYS_DIV_RST 4'hF
`define SCD_PWM_PRE_RST 3'h7
`define SCD_ALT_DIV_RST 6'h0F

// Smallest divisor code allowed while the PLL feeds the system
`define SCD_MIN_DIV 6'h03

`endif

// [src/scd_clock_divider.sv]
`timescale 1ns/100ps
`include "scd_regs.svh"

// Operation
// - Divide selected source by four-bit system divisor
// - PLL in use: clamp divisor to minimum
// - Without PLL, small divisors apply unclamped
// - Divider enable bit; forced on with PLL
// - Alternate select takes alternate divisor field
// - PWM divider enable picks predivider output
// - Predivide codes give /2 to /64
// - PWM ticks coincide with system ticks
// - Power-down bit drives PLL input directly
// - Bypass clocks system from oscillator directly
module scd_clock_divider (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register port
   input wire scd_pkg::scd_addr_t addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [31:0] rd_data,
   // PLL side
   input wire logic pll_tick,
   output logic pll_power_down,
   // Generated clock enables
   output logic sys_clk_tick,
   output logic pwm_clk_tick
);
   import scd_pkg::*;

   //------------------------------------------------------------
   // Configuration storage
   //------------------------------------------------------------
   logic [3:0] system_divisor;
   logic system_divider_enable;
   logic pwm_divider_enable;
   scd_pwm_code_t pwm_predivide;
   logic bypass;
   logic alt_config_select;
   scd_div_t alt_system_divisor;

   // Address decode
   wire sel_run = (addr == `SCD_RUN_CFG_OFS);
   wire sel_second = (addr == `SCD_SECOND_CFG_OFS);
   wire wr_run = wr_strobe & sel_run;
   wire wr_second = wr_strobe & sel_second;

   // Only defined fields store; reserved positions are never written
   // reserved ignore writes
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         system_divisor <= `SCD_SYS_DIV_RST;
         system_divider_enable <= 1'b0;
         pwm_divider_enable <= 1'b0;
         pwm_predivide <= `SCD_PWM_PRE_RST;
         pll_power_down <= 1'b1;
         bypass <= 1'b1;
      end else if (wr_run) begin
         system_divisor <= wr_data[`SCD_SYS_DIV_HI:`SCD_SYS_DIV_LO];
         system_divider_enable <= wr_data[`SCD_SYS_DIV_EN_BIT];
         pwm_divider_enable <= wr_data[`SCD_PWM_DIV_EN_BIT];
         pwm_predivide <= wr_data[`SCD_PWM_PRE_HI:`SCD_PWM_PRE_LO];
         pll_power_down <= wr_data[`SCD_POWER_DOWN_BIT];
         bypass <= wr_data[`SCD_BYPASS_BIT];
      end
   end

   // Second configuration register
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         alt_config_select <= 1'b0;
         alt_system_divisor <= `SCD_ALT_DIV_RST;
      end else if (wr_second) begin
         alt_config_select <= wr_data[`SCD_ALT_SEL_BIT];
         alt_system_divisor <= wr_data[`SCD_ALT_DIV_HI:`SCD_ALT_DIV_LO];
      end
   end

   //------------------------------------------------------------
   // Read path
   //------------------------------------------------------------
   logic [31:0] run_image;
   logic [31:0] second_image;
   logic [31:0] next_rd_data;

   always_comb begin
      run_image = 32'h0000_0000;
      run_image[`SCD_SYS_DIV_HI:`SCD_SYS_DIV_LO] = system_divisor;
      run_image[`SCD_SYS_DIV_EN_BIT] = system_divider_enable;
      run_image[`SCD_PWM_DIV_EN_BIT] = pwm_divider_enable;
      run_image[`SCD_PWM_PRE_HI:`SCD_PWM_PRE_LO] = pwm_predivide;
      run_image[`SCD_POWER_DOWN_BIT] = pll_power_down;
      run_image[`SCD_FIXED_ONE_BIT] = 1'b1;
      run_image[`SCD_BYPASS_BIT] = bypass;
   end

   // Alternate register image
   always_comb begin
      second_image = 32'h0000_0000;
      second_image[`SCD_ALT_SEL_BIT] = alt_config_select;
      second_image[`SCD_ALT_DIV_HI:`SCD_ALT_DIV_LO] = alt_system_divisor;
   end

   // Unmapped addresses read zero
   assign next_rd_data = !rd_strobe ? 32'h0000_0000 :
                         sel_run ? run_image :
                         sel_second ? second_image : 32'h0000_0000;

   // Data stands only in the cycle after the strobe
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rd_data <= 32'h0000_0000;
      end else begin
         rd_data <= next_rd_data;
      end
   end

   //------------------------------------------------------------
   // PLL tick synchroniser
   //------------------------------------------------------------
   logic pll_meta;
   logic pll_sync;

   // Second stage is the only reader of the first
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pll_meta <= 1'b0;
         pll_sync <= 1'b0;
      end else begin
         pll_meta <= pll_tick;
         pll_sync <= pll_meta;
      end
   end

   //------------------------------------------------------------
   // Divisor selection
   //------------------------------------------------------------
   wire use_pll = ~bypass;
   wire scd_div_t prog_div = alt_config_select ? alt_system_divisor :
                             {2'h0, system_divisor};
   // clamp with PLL; no clamp otherwise
   wire below_min = (prog_div < `SCD_MIN_DIV);
   wire scd_div_t eff_div = (use_pll && below_min) ? `SCD_MIN_DIV :
                            prog_div;
   wire div_used = system_divider_enable | use_pll;
   // source is oscillator (every cycle) or the PLL tick
   wire src_tick = bypass ? 1'b1 : pll_sync;

   //------------------------------------------------------------
   // System divider
   //------------------------------------------------------------
   scd_div_t sys_cnt;
   scd_div_t next_sys_cnt;
   logic next_sys_tick;
   // A shrinking divisor wraps at once rather than running to 63
   wire sys_wrap = (sys_cnt >= eff_div);

   // count source ticks up to divisor
   assign next_sys_tick = src_tick & (~div_used | sys_wrap);
   assign next_sys_cnt = !src_tick ? sys_cnt :
                         (next_sys_tick ? 6'h00 : sys_cnt + 6'h01);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sys_cnt <= 6'h00;
         sys_clk_tick <= 1'b0;
      end else begin
         sys_cnt <= next_sys_cnt;
         sys_clk_tick <= next_sys_tick;
      end
   end

   //------------------------------------------------------------
   // PWM predivider
   //------------------------------------------------------------
   logic [5:0] pwm_cnt;
   logic [5:0] pwm_mask;
   logic next_pwm_tick;

   // codes 5 to 7 all give /64
   assign pwm_mask = (pwm_predivide == 3'h0) ? 6'h01 :
                     (pwm_predivide == 3'h1) ? 6'h03 :
                     (pwm_predivide == 3'h2) ? 6'h07 :
                     (pwm_predivide == 3'h3) ? 6'h0F :
                     (pwm_predivide == 3'h4) ? 6'h1F : 6'h3F;

   // predivided edge only on a system tick
   wire pre_tick = next_sys_tick & ((pwm_cnt & pwm_mask) == pwm_mask);
   assign next_pwm_tick = pwm_divider_enable ? pre_tick : next_sys_tick;

   // Counter advances once per system tick
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pwm_cnt <= 6'h00;
         pwm_clk_tick <= 1'b0;
      end else begin
         pwm_cnt <= next_sys_tick ? pwm_cnt + 6'h01 : pwm_cnt;
         pwm_clk_tick <= next_pwm_tick;
      end
   end

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   sequence run_write_s;
      wr_strobe && sel_run;
   endsequence

   sequence run_read_s;
      rd_strobe && sel_run;
   endsequence

   pll_power_down_follows_a: assert property (
      @(posedge core_clk) disable iff (reset)
      run_write_s |=> pll_power_down == $past(wr_data[`SCD_POWER_DOWN_BIT]))
      else $error("power-down output does not follow write");

   reserved_read_a: assert property (
      @(posedge core_clk) disable iff (reset)
      run_read_s |=> rd_data[12] && !rd_data[21] && !rd_data[10]
                     && rd_data[16:14] == 3'h0 && rd_data[31:27] == 5'h00)
      else $error("reserved bits read wrong");

   pwm_aligned_a: assert property (
      @(posedge core_clk) disable iff (reset)
      pwm_clk_tick |-> sys_clk_tick)
      else $error("PWM tick without system tick");

   pll_clamp_a: assert property (
      @(posedge core_clk) disable iff (reset)
      $past(use_pll) && sys_clk_tick |-> $past(sys_cnt) >= `SCD_MIN_DIV)
      else $error("divisor not clamped with PLL");

   // zero divisor on bypass ticks next cycle
   bypass_noclamp_a: assert property (
      @(posedge core_clk) disable iff (reset)
      bypass && system_divider_enable && prog_div == 6'h00 |=> sys_clk_tick)
      else $error("divisor clamped without PLL");

   alt_divisor_a: assert property (
      @(posedge core_clk) disable iff (reset)
      alt_config_select |-> prog_div == alt_system_divisor)
      else $error("alternate divisor ignored");

   // bypass without divider ticks every cycle
   bypass_direct_a: assert property (
      @(posedge core_clk) disable iff (reset)
      (bypass && !system_divider_enable)[*2] |-> sys_clk_tick)
      else $error("bypass clock missing a tick");

   // tick only once the divisor is reached
   sys_divide_a: assert property (
      @(posedge core_clk) disable iff (reset)
      $past(div_used) && sys_clk_tick |->
         $past(sys_cnt) >= $past(eff_div))
      else $error("system tick before divisor count");

   // divider used with PLL regardless of enable
   pll_forced_a: assert property (
      @(posedge core_clk) disable iff (reset)
      use_pll && src_tick && sys_cnt == 6'h00 |=> !sys_clk_tick)
      else $error("divider bypassed while PLL selected");

   // without predivider PWM equals system tick
   pwm_select_a: assert property (
      @(posedge core_clk) disable iff (reset)
      !$past(pwm_divider_enable) |-> pwm_clk_tick == sys_clk_tick)
      else $error("PWM tick differs from system tick");

   // predivided tick lands on a counter wrap
   pwm_rate_a: assert property (
      @(posedge core_clk) disable iff (reset)
      pwm_clk_tick && $past(pwm_divider_enable) |->
         (pwm_cnt & $past(pwm_mask)) == 6'h00)
      else $error("PWM tick off the predivide boundary");

endmodule : scd_clock_divider

// [verif/scd_clock_divider_test.sv]
`timescale 1ns/100ps
`include "scd_regs.svh"

module scd_clock_divider_test;
   import scd_pkg::*;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic core_clk, reset, wr_strobe, rd_strobe, pll_tick, rd_seen;
   scd_addr_t addr;
   logic [31:0] wr_data, rd_data, w;
   logic pll_power_down, sys_clk_tick, pwm_clk_tick;
   logic [31:0] exp_q[$];
   int mismatches, checked, cycles, i;
   int dv[4];

   scd_clock_divider dut_u (
      .core_clk(core_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
      .pll_tick(pll_tick), .pll_power_down(pll_power_down),
      .sys_clk_tick(sys_clk_tick), .pwm_clk_tick(pwm_clk_tick)
   );

   // 50 ns period
   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;

   // ----------------------------------------
   // Compare and report
   // ----------------------------------------
   task cmp_word(input logic [31:0] want, input logic [31:0] got);
      checked++;
      if (got !== want) begin
         mismatches++;
         $display("CHECK FAILED %0t read %h want %h", $time, got, want);
      end
   endtask : cmp_word

   task cmp_bit(input logic got, input logic want);
      checked++;
      if (got !== want) begin
         mismatches++;
         $display("CHECK FAILED %0t flag %b want %b", $time, got, want);
      end
   endtask : cmp_bit

   task cmp_count(input int got, input int want);
      checked++;
      if (got != want) begin
         mismatches++;
         $display("CHECK FAILED %0t period %0d want %0d", $time, got, want);
      end
   endtask : cmp_count

   task summarize;
      if (mismatches == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   // Watches read data, tick pairing and the run-time ceiling; the PLL
   // input toggles each cycle so a source tick comes every 2 cycles
   always @(posedge core_clk) begin
      if (rd_seen === 1'b1)
         cmp_word(exp_q.pop_front(), rd_data);
      if (pwm_clk_tick === 1'b1)
         cmp_bit(sys_clk_tick, 1'b1);
      rd_seen <= rd_strobe;
      pll_tick <= ~pll_tick;
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         summarize();
      end
   end

   // ----------------------------------------
   // Bus and measurement tasks
   // ----------------------------------------
   task wr(input scd_addr_t a, input logic [31:0] d);
      @(posedge core_clk);
      wr_strobe <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge core_clk);
      wr_strobe <= 1'b0;
   endtask : wr

   task rd(input scd_addr_t a, input logic [31:0] want);
      @(posedge core_clk);
      exp_q.push_back(want);
      rd_strobe <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd_strobe <= 1'b0;
   endtask : rd

   function automatic logic tk(input bit pwm);
      return pwm ? pwm_clk_tick : sys_clk_tick;
   endfunction : tk

   // Third gap only: the first two may straddle the config change
   task period(input bit pwm, input int want);
      int k, n;
      for (k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge core_clk);
            n++;
         end while (tk(pwm) !== 1'b1 && n < 3000);
      end
      cmp_count(n, want);
   endtask : period

   // Run config image: divisor, div enable, pwm enable, code, pd, bypass
   function automatic logic [31:0] rc(input logic [3:0] sd,
      input logic u, input logic pe, input logic [2:0] pc,
      input logic pd, input logic by);
      return {5'h00, sd, u, 1'b0, pe, pc, 3'h0, pd, 1'b0, by, 11'h000};
   endfunction : rc

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      reset = 1'b1;
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
      addr = 8'h00;
      wr_data = 32'h0;
      pll_tick = 1'b0;
      rd_seen = 1'b0;
      mismatches = 0;
      checked = 0;
      cycles = 0;
      void'($urandom(32'h02678220));
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      rd(`SCD_RUN_CFG_OFS, 32'h078E3800);
      rd(`SCD_SECOND_CFG_OFS, 32'h07800000);
      rd(8'h04, 32'h0);
      cmp_bit(pll_power_down, 1'b1);
      period(0, 1);
      period(1, 1);
      // Random images: fixed bits must not move
      for (i = 0; i < 4; i++) begin
         w = $urandom;
         wr(`SCD_RUN_CFG_OFS, w);
         rd(`SCD_RUN_CFG_OFS, (w & 32'h07DE2800) | 32'h00001000);
         cmp_bit(pll_power_down, w[13]);
      end
      // Oscillator path, divisors below the PLL minimum included
      dv = '{0, 1, 2, 0};
      dv[3] = $urandom_range(15, 4);
      for (i = 0; i < 4; i++) begin
         wr(`SCD_RUN_CFG_OFS, rc(dv[i][3:0], 1'b1, 1'b0, 3'h0, 1'b1, 1'b1));
         period(0, dv[i] + 1);
      end
      wr(`SCD_RUN_CFG_OFS, rc(4'h5, 1'b0, 1'b0, 3'h0, 1'b1, 1'b1));
      period(0, 1);
      for (i = 0; i < 8; i++) begin
         wr(`SCD_RUN_CFG_OFS, rc(4'h0, 1'b0, 1'b1, i[2:0], 1'b1, 1'b1));
         period(1, 2 ** ((i < 5) ? i + 1 : 6));
      end
      wr(`SCD_RUN_CFG_OFS, rc(4'h1, 1'b1, 1'b1, 3'h0, 1'b1, 1'b1));
      period(1, 4);
      // PLL path: divider forced on, clamp to the minimum
      wr(`SCD_RUN_CFG_OFS, rc(4'h1, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0));
      period(0, 8);
      cmp_bit(pll_power_down, 1'b0);
      wr(`SCD_RUN_CFG_OFS, rc(4'h6, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0));
      period(0, 14);
      // Alternate divisor overrides the run divisor
      wr(`SCD_SECOND_CFG_OFS, 32'h82000000);
      wr(`SCD_RUN_CFG_OFS, rc(4'h1, 1'b1, 1'b0, 3'h0, 1'b1, 1'b1));
      period(0, 5);
      wr(`SCD_SECOND_CFG_OFS, 32'h80800000);
      rd(`SCD_SECOND_CFG_OFS, 32'h80800000);
      wr(`SCD_RUN_CFG_OFS, rc(4'h9, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0));
      period(0, 8);
      repeat (3) @(posedge core_clk);
      summarize();
   end

endmodule : scd_clock_divider_test
